/* File: design/apvm_consts.svh */
// Register indices, field positions, reset values and counts for the playback mixer
`ifndef APVM_CONSTS_SVH
`define APVM_CONSTS_SVH
`define APVM_IDX_RATE_LO    16'hFC34
`define APVM_IDX_RATE_HI    16'hFC35
`define APVM_IDX_LEFT_LO    16'hFC36
`define APVM_IDX_LEFT_UP    16'hFC37
`define APVM_IDX_RIGHT_LO   16'hFC38
`define APVM_IDX_RIGHT_UP   16'hFC39
`define APVM_IDX_VOLUME     16'hFEC0
`define APVM_IDX_SEC_CFG    16'hFEC1
`define APVM_IDX_SEC_L_LO   16'hFEC2
`define APVM_IDX_SEC_L_UP   16'hFEC3
`define APVM_IDX_SEC_R_LO   16'hFEC4
`define APVM_IDX_SEC_R_UP   16'hFEC5
`define APVM_IDX_TEST_CTRL  16'hFECF
`define APVM_ADDR_W         18
`define APVM_RST16          16'h0000
`define APVM_SLOW_CLK_BIT   12
`define APVM_HIRATE_BIT     11
`define APVM_URUN_BIT       14
`define APVM_FULL_BIT       13
`define APVM_ENA_BIT        12
`define APVM_TICK_NORMAL    7'h7F
`define APVM_TICK_FAST      7'h3F
`define APVM_HIRATE_MAX     20'h82000
`define APVM_SAT_MAX        23'sh07FFFF
`define APVM_SAT_MIN        -23'sh080000
`define APVM_FINE_MAX       4'hB
`define APVM_RESP_OKAY      2'h0
`define APVM_RESP_SLVERR    2'h2
`endif

/* File: design/apvm_pkg.sv */
// Types shared by the playback mixer
package apvm_pkg;
  typedef struct packed {
    logic signed [19:0] left;
    logic signed [19:0] right;
  } apvm_stereo_t;
  typedef enum logic {ST_IDLE, ST_RUN} apvm_state_t;
endpackage

/* File: design/apvm_mixer.sv */
// Playback rate generator, volume, secondary mixer and AXI4-Lite registers
//
// The AXI4-Lite register port was decided locally.
`include "apvm_consts.svh"
// Contract
// - Rate from 20-bit accumulator rollover
// - Normal mode rate scaling, word 1..max
// - High-rate scaling, word capped at 532480
// - Zero rate word halts playback and secondary logic; extClk divider keeps running
// - Converter logic clocked from crystal clock
// - Primary sample split upper/low byte
// - Test bit 12 picks slow clock
// - Test bit 11 enables high-rate mode
// - Coarse attenuation 6 dB per step
// - Fine gain 0.5 dB steps, 0..11
// - Fine values 12..15 give 0 dB
// - Secondary sample split 16 plus 4
// - Consume while empty sets underrun
// - Full set by writes, cleared on consume
// - Config bit 12 enables secondary path
// - Secondary period is interval plus one
// - Secondary consume raises request
// - Mixed sum saturates to 20 bits
// - Secondary zero-order hold, no filter
module apvm_mixer #(
  parameter logic [7:0] EXT_HALF_FAST = 8'h04,
  parameter logic [7:0] EXT_HALF_SLOW = 8'h08
) (
  input  wire logic                     clock,
  input  wire logic                     rst_n,
  input  wire logic [`APVM_ADDR_W-1:0]  awaddr,
  input  wire logic                     awvalid,
  output logic                          awready,
  input  wire logic [31:0]              wdata,
  input  wire logic [3:0]               wstrb,
  input  wire logic                     wvalid,
  output logic                          wready,
  output logic [1:0]                    bresp,
  output logic                          bvalid,
  input  wire logic                     bready,
  input  wire logic [`APVM_ADDR_W-1:0]  araddr,
  input  wire logic                     arvalid,
  output logic                          arready,
  output logic [31:0]                   rdata,
  output logic [1:0]                    rresp,
  output logic                          rvalid,
  input  wire logic                     rready,
  output apvm_pkg::apvm_stereo_t        dacOut,
  output logic                          convClkEn,
  output logic                          playSampleReq,
  output logic                          secSampleReq,
  output logic                          extClk
);
  import apvm_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  logic [`APVM_ADDR_W-1:0] awAddr_q;
  logic [31:0]             wData_q;
  logic [3:0]              wStrb_q;
  logic [15:0] rateLo_q, leftUp_q, rightUp_q, vol_q, secLUp_q, secRUp_q, testCtrl_q;
  logic [3:0]  rateHi_q, secLLo_q, secRLo_q;
  logic [7:0]  leftLoB_q, rightLoB_q;
  logic [11:0] secInt_q, secCnt_q;
  logic        secEn_q, urun_q, full_q, wroteL_q, wroteR_q;
  logic [19:0] acc_q;
  logic [6:0]  divCnt_q;
  logic [7:0]  extCnt_q;
  logic signed [23:0] playL_q, playR_q;
  logic signed [19:0] secHoldL_q, secHoldR_q;
  apvm_state_t st_q, st_d;
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction
  function automatic logic mapped(input logic [15:0] idx);
    mapped = (idx >= `APVM_IDX_RATE_LO && idx <= `APVM_IDX_RIGHT_UP) ||
             (idx >= `APVM_IDX_VOLUME && idx <= `APVM_IDX_SEC_R_UP) ||
             (idx == `APVM_IDX_TEST_CTRL);
  endfunction
  function automatic logic [15:0] regView(input logic [15:0] idx);
    case (idx)
      `APVM_IDX_RATE_LO:   regView = rateLo_q;
      `APVM_IDX_RATE_HI:   regView = {12'h000, rateHi_q};
      `APVM_IDX_LEFT_LO:   regView = {leftLoB_q, 8'h00};
      `APVM_IDX_LEFT_UP:   regView = leftUp_q;
      `APVM_IDX_RIGHT_LO:  regView = {rightLoB_q, 8'h00};
      `APVM_IDX_RIGHT_UP:  regView = rightUp_q;
      `APVM_IDX_VOLUME:    regView = vol_q;
      `APVM_IDX_SEC_CFG:   regView = {1'b0, urun_q, full_q, secEn_q, secInt_q};
      `APVM_IDX_SEC_L_LO:  regView = {secLLo_q, 12'h000};
      `APVM_IDX_SEC_L_UP:  regView = secLUp_q;
      `APVM_IDX_SEC_R_LO:  regView = {secRLo_q, 12'h000};
      `APVM_IDX_SEC_R_UP:  regView = secRUp_q;
      `APVM_IDX_TEST_CTRL: regView = testCtrl_q;
      default:             regView = `APVM_RST16;
    endcase
  endfunction
  // 0.5 dB steps as Q2.14 gain; out-of-range codes fall back to unity
  function automatic logic [15:0] fineGain(input logic [3:0] f);
    case (f)
      4'h0:    fineGain = 16'h4000;
      4'h1:    fineGain = 16'h43CB;
      4'h2:    fineGain = 16'h47CF;
      4'h3:    fineGain = 16'h4C10;
      4'h4:    fineGain = 16'h5092;
      4'h5:    fineGain = 16'h5558;
      4'h6:    fineGain = 16'h5A67;
      4'h7:    fineGain = 16'h5FC2;
      4'h8:    fineGain = 16'h656E;
      4'h9:    fineGain = 16'h6B71;
      4'hA:    fineGain = 16'h71CF;
      4'hB:    fineGain = 16'h788E;
      default: fineGain = 16'h4000;
    endcase
  endfunction
  // Shift first so the product never needs more than 41 bits
  function automatic logic signed [21:0] scaleSample(input logic signed [23:0] s,
                                                     input logic [3:0] atten,
                                                     input logic [3:0] fine);
    logic signed [23:0] sh;
    logic signed [40:0] prod;
    sh = s >>> atten;
    prod = sh * $signed({1'b0, fineGain(fine)});
    scaleSample = prod[39:18];
  endfunction
  function automatic logic signed [19:0] sat20(input logic signed [22:0] v);
    if (v > `APVM_SAT_MAX)
      sat20 = 20'sh7FFFF;
    else if (v < `APVM_SAT_MIN)
      sat20 = -20'sh80000;
    else
      sat20 = v[19:0];
  endfunction
  // Bus decode
  wire logic [15:0] wIdx    = awAddr_q[`APVM_ADDR_W-1:2];
  wire logic [15:0] rIdx    = araddr[`APVM_ADDR_W-1:2];
  wire logic        doWrite = !awready && !wready && !bvalid;
  wire logic [15:0] wrM     = merge16(regView(wIdx), wData_q, wStrb_q);
  wire logic        wrHit   = doWrite && mapped(wIdx);
  wire logic        secLWr  = wrHit && wIdx == `APVM_IDX_SEC_L_UP;
  wire logic        secRWr  = wrHit && wIdx == `APVM_IDX_SEC_R_UP;
  wire logic        urunClr = wrHit && wIdx == `APVM_IDX_SEC_CFG &&
                              wStrb_q[1] && wData_q[`APVM_URUN_BIT];
  // Rate path
  wire logic [19:0] rateWord = {rateHi_q, rateLo_q};
  wire logic        hiRate   = testCtrl_q[`APVM_HIRATE_BIT];
  wire logic [19:0] effRate  = (hiRate && rateWord > `APVM_HIRATE_MAX) ?
                               `APVM_HIRATE_MAX : rateWord;
  wire logic        running  = st_q == ST_RUN;
  wire logic [6:0]  tickMax  = hiRate ? `APVM_TICK_FAST : `APVM_TICK_NORMAL;
  wire logic        tick     = running && divCnt_q == tickMax;
  wire logic [20:0] accSum   = {1'b0, acc_q} + {1'b0, effRate};
  wire logic        rollover = tick && accSum[20];
  // Volume and mixing
  wire logic signed [21:0] scaledL = scaleSample(playL_q, vol_q[11:8], vol_q[15:12]);
  wire logic signed [21:0] scaledR = scaleSample(playR_q, vol_q[3:0], vol_q[7:4]);
  wire logic signed [19:0] secMixL = secEn_q ? secHoldL_q : 20'sh00000;
  wire logic signed [19:0] secMixR = secEn_q ? secHoldR_q : 20'sh00000;
  wire logic signed [22:0] sumL    = 23'(scaledL) + 23'(secMixL);
  wire logic signed [22:0] sumR    = 23'(scaledR) + 23'(secMixR);
  // Secondary path
  wire logic secFire  = running && secEn_q && secCnt_q == secInt_q;
  wire logic bothDone = (wroteL_q || secLWr) && (wroteR_q || secRWr);
  wire logic [7:0] extHalf = testCtrl_q[`APVM_SLOW_CLK_BIT] ?
                             EXT_HALF_SLOW : EXT_HALF_FAST;
  always_comb
  begin
    case (rateWord == 20'h00000)
      1'b1:    st_d = ST_IDLE;
      default: st_d = ST_RUN;
    endcase
  end
  // AXI4-Lite write channel; address and data taken in either order
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awready  <= 1'b1;
      wready   <= 1'b1;
      bvalid   <= 1'b0;
      bresp    <= `APVM_RESP_OKAY;
      awAddr_q <= '0;
      wData_q  <= '0;
      wStrb_q  <= '0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awAddr_q <= awaddr;
        awready  <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wData_q <= wdata;
        wStrb_q <= wstrb;
        wready  <= 1'b0;
      end
      if (doWrite)
      begin
        bvalid <= 1'b1;
        bresp  <= mapped(wIdx) ? `APVM_RESP_OKAY : `APVM_RESP_SLVERR;
      end
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end
  // AXI4-Lite read channel
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= `APVM_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= {16'h0000, regView(rIdx)};
      rresp   <= mapped(rIdx) ? `APVM_RESP_OKAY : `APVM_RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end
  // Register storage
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rateLo_q   <= `APVM_RST16;
      rateHi_q   <= '0;
      leftLoB_q  <= '0;
      leftUp_q   <= `APVM_RST16;
      rightLoB_q <= '0;
      rightUp_q  <= `APVM_RST16;
      vol_q      <= `APVM_RST16;
      secEn_q    <= 1'b0;
      secInt_q   <= '0;
      secLLo_q   <= '0;
      secLUp_q   <= `APVM_RST16;
      secRLo_q   <= '0;
      secRUp_q   <= `APVM_RST16;
      testCtrl_q <= `APVM_RST16;
    end
    else if (wrHit)
    begin
      case (wIdx)
        `APVM_IDX_RATE_LO:   rateLo_q   <= wrM;
        `APVM_IDX_RATE_HI:   rateHi_q   <= wrM[3:0];
        `APVM_IDX_LEFT_LO:   leftLoB_q  <= wrM[15:8];
        `APVM_IDX_LEFT_UP:   leftUp_q   <= wrM;
        `APVM_IDX_RIGHT_LO:  rightLoB_q <= wrM[15:8];
        `APVM_IDX_RIGHT_UP:  rightUp_q  <= wrM;
        `APVM_IDX_VOLUME:    vol_q      <= wrM;
        `APVM_IDX_SEC_CFG:
        begin
          secEn_q  <= wrM[`APVM_ENA_BIT];
          secInt_q <= wrM[11:0];
        end
        `APVM_IDX_SEC_L_LO:  secLLo_q   <= wrM[15:12];
        `APVM_IDX_SEC_L_UP:  secLUp_q   <= wrM;
        `APVM_IDX_SEC_R_LO:  secRLo_q   <= wrM[15:12];
        `APVM_IDX_SEC_R_UP:  secRUp_q   <= wrM;
        `APVM_IDX_TEST_CTRL: testCtrl_q <= wrM;
        default:             testCtrl_q <= testCtrl_q;
      endcase
    end
  end
  // Rate generator; everything freezes while idle
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q          <= ST_IDLE;
      divCnt_q      <= '0;
      acc_q         <= '0;
      playL_q       <= '0;
      playR_q       <= '0;
      playSampleReq <= 1'b0;
      convClkEn     <= 1'b0;
      dacOut        <= '0;
    end
    else
    begin
      st_q          <= st_d;
      convClkEn     <= running;
      playSampleReq <= rollover;
      if (running)
      begin
        divCnt_q <= tick ? 7'h00 : divCnt_q + 7'h01;
        dacOut   <= '{left: sat20(sumL), right: sat20(sumR)};
      end
      if (tick)
        acc_q <= accSum[19:0];
      if (rollover)
      begin
        playL_q <= {leftUp_q, leftLoB_q};
        playR_q <= {rightUp_q, rightLoB_q};
      end
    end
  end
  // Secondary path; a write completing with a consume still marks full
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      secCnt_q     <= '0;
      full_q       <= 1'b0;
      urun_q       <= 1'b0;
      wroteL_q     <= 1'b0;
      wroteR_q     <= 1'b0;
      secHoldL_q   <= '0;
      secHoldR_q   <= '0;
      secSampleReq <= 1'b0;
    end
    else
    begin
      secCnt_q     <= (secFire || !(running && secEn_q)) ? 12'h000 : secCnt_q + 12'h001;
      secSampleReq <= secFire && full_q;
      wroteL_q     <= bothDone ? 1'b0 : (wroteL_q || secLWr);
      wroteR_q     <= bothDone ? 1'b0 : (wroteR_q || secRWr);
      if (bothDone)
        full_q <= 1'b1;
      else if (secFire && full_q)
        full_q <= 1'b0;
      if (secFire && !full_q)
        urun_q <= 1'b1;
      else if (urunClr)
        urun_q <= 1'b0;
      if (secFire && full_q)
      begin
        secHoldL_q <= {secLUp_q, secLLo_q};
        secHoldR_q <= {secRUp_q, secRLo_q};
      end
    end
  end
  // External converter clock; divider runs regardless of playback state
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      extCnt_q <= '0;
      extClk   <= 1'b0;
    end
    else if (extCnt_q >= extHalf - 8'h01)
    begin
      extCnt_q <= '0;
      extClk   <= !extClk;
    end
    else
      extCnt_q <= extCnt_q + 8'h01;
  end
  // State lags the rate word by one edge, so the halt is checked one cycle later
  idle_halt_a: assert property ((rateWord == 20'h00000) |=>
    !running ##1 (!convClkEn && $stable(acc_q)))
    else $error("converter not halted in idle");
  acc_step_a: assert property (tick |=> acc_q == $past(accSum[19:0]))
    else $error("accumulator step wrong");
  rollover_req_a: assert property (tick && accSum[20] |=> playSampleReq)
    else $error("rollover did not request a sample");
  tick_space_a: assert property (tick |=> !tick [*8])
    else $error("rate ticks too close");
  hirate_tick_a: assert property (tick |-> divCnt_q == (hiRate ? 7'h3F : 7'h7F))
    else $error("tick spacing does not match mode");
  hirate_cap_a: assert property (hiRate |-> effRate <= 20'h82000)
    else $error("high-rate word above cap");
  fine_clamp_a: assert property (vol_q[15:12] > 4'hB |->
    scaledL == 22'((playL_q >>> vol_q[11:8]) >>> 4))
    else $error("fine code above eleven not unity");
  sat_high_a: assert property (running && sumL > 23'sh07FFFF |=>
    dacOut.left == 20'sh7FFFF)
    else $error("left sum not saturated");
  full_set_a: assert property (bothDone |=> full_q)
    else $error("full flag not set after both writes");
  underrun_set_a: assert property (secFire && !full_q |=> urun_q)
    else $error("underrun not flagged");
  sec_consume_a: assert property (secFire && full_q && !bothDone |=>
    secSampleReq && !full_q)
    else $error("consume did not request or clear full");
  sec_period_a: assert property (secFire && secInt_q != 12'h000 |=> !secFire)
    else $error("secondary period too short");
  play_req_c: cover property (playSampleReq ##1 !playSampleReq [*8] ##1 convClkEn);
  sec_consume_c: cover property (full_q ##1 secSampleReq);
  underrun_c: cover property ($rose(urun_q));
  saturate_c: cover property (running && sumR < -23'sh080000);
endmodule

/* File: dv/apvm_dac_model.sv */
// Behavioural stereo converter that takes the block's samples while its clock runs
module apvm_dac_model (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire apvm_pkg::apvm_stereo_t dacOut,
  input  wire logic                   convClkEn,
  output apvm_pkg::apvm_stereo_t      heldSample
);
  timeunit 1ns;
  timeprecision 1ps;
  import apvm_pkg::*;
  // Same crystal clock as the block, no PLL in between
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      heldSample <= '0;
    else if (convClkEn)
      heldSample <= dacOut;  // Halted clock keeps the last sample
  end
endmodule

/* File: dv/testbench.sv */
// Self-checking bench for the playback rate, volume and secondary mixer
`include "apvm_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import apvm_pkg::*;
  logic                    clock, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [`APVM_ADDR_W-1:0] awaddr, araddr;
  logic [31:0]             wdata, rdata, seed;
  logic [3:0]              wstrb;
  logic [1:0]              bresp, rresp;
  logic                    awready, wready, bvalid, arready, rvalid;
  logic                    convClkEn, playSampleReq, secSampleReq, extClk, extPrev;
  apvm_stereo_t            dacOut, heldSample;
  logic [33:0]             expQ[$];
  logic [15:0]             r;
  int                      miscompares, num_checks, playCnt, playGap, playTotal, n0;
  int                      secCnt, secGap, extCnt, extGap;
  logic [15:0]             idxList [13] = '{`APVM_IDX_RATE_LO, `APVM_IDX_RATE_HI,
    `APVM_IDX_LEFT_LO, `APVM_IDX_LEFT_UP, `APVM_IDX_RIGHT_LO, `APVM_IDX_RIGHT_UP,
    `APVM_IDX_VOLUME, `APVM_IDX_SEC_CFG, `APVM_IDX_SEC_L_LO, `APVM_IDX_SEC_L_UP,
    `APVM_IDX_SEC_R_LO, `APVM_IDX_SEC_R_UP, `APVM_IDX_TEST_CTRL};

  apvm_mixer u_dut (
    .clock(clock), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .dacOut(dacOut), .convClkEn(convClkEn), .playSampleReq(playSampleReq),
    .secSampleReq(secSampleReq), .extClk(extClk)
  );
  apvm_dac_model u_model (
    .clock(clock), .rst_n(rst_n), .dacOut(dacOut), .convClkEn(convClkEn),
    .heldSample(heldSample)
  );

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  function automatic logic [15:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction

  task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic timedOut();
    miscompares++;
    give_verdict();
  endtask

  // Bus master: payload held until each channel's ready is sampled high
  task automatic wr(input logic [15:0] idx, input logic [15:0] val, input logic [1:0] er);
    int n;
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge clock);
      awvalid <= awvalid & ~awready;
      wvalid <= wvalid & ~wready;
      if (bvalid === 1'b1)
        break;
    end
    if (n == 64)
      timedOut();
    check("bresp", bresp, er);
    bready <= 1'b0;
    @(posedge clock);
  endtask

  // Expected answer queued here, compared by the monitor below
  task automatic rd(input logic [15:0] idx, input logic [15:0] ev, input logic [1:0] er);
    int n;
    expQ.push_back({er, 16'h0000, ev});
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge clock);
      arvalid <= arvalid & ~arready;
      if (rvalid === 1'b1)
        break;
    end
    if (n == 64)
      timedOut();
    rready <= 1'b0;
    @(posedge clock);
  endtask

  // Waits for a play (0) or secondary (1) request, then lets the sample settle
  task automatic waitFor(input int which);
    int n;
    for (n = 0; n < 3000; n++)
    begin
      @(posedge clock);
      if ((which == 0) ? (playSampleReq === 1'b1) : (secSampleReq === 1'b1))
        break;
    end
    if (n == 3000)
      timedOut();
    repeat (3) @(posedge clock);
  endtask

  always @(posedge clock)
  begin
    playCnt++;
    secCnt++;
    extCnt++;
    if (playSampleReq === 1'b1)
    begin
      playGap = playCnt;
      playCnt = 0;
      playTotal++;
    end
    if (secSampleReq === 1'b1)
    begin
      secGap = secCnt;
      secCnt = 0;
    end
    if (extClk !== extPrev)
    begin
      extGap = extCnt;
      extCnt = 0;
    end
    extPrev = extClk;
    if (rvalid === 1'b1 && rready === 1'b1)
      check("rdata", {rresp, rdata}, expQ.pop_front());
  end

  initial
  begin
    seed = 32'h71D9;
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'h3;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    foreach (idxList[i])
      rd(idxList[i], `APVM_RST16, `APVM_RESP_OKAY);
    rd(16'h0000, 16'h0000, `APVM_RESP_SLVERR);
    wr(16'hFC3A, 16'h1234, `APVM_RESP_SLVERR);
    r = xs();
    wr(`APVM_IDX_VOLUME, r, `APVM_RESP_OKAY);
    rd(`APVM_IDX_VOLUME, r, `APVM_RESP_OKAY);
    r = xs();
    wr(`APVM_IDX_RATE_LO, r, `APVM_RESP_OKAY);
    rd(`APVM_IDX_RATE_LO, r, `APVM_RESP_OKAY);
    r = xs();
    wr(`APVM_IDX_RATE_HI, r, `APVM_RESP_OKAY);
    rd(`APVM_IDX_RATE_HI, {12'h000, r[3:0]}, `APVM_RESP_OKAY);
    wr(`APVM_IDX_RATE_HI, 16'h0000, `APVM_RESP_OKAY);
    wr(`APVM_IDX_RATE_LO, 16'h0000, `APVM_RESP_OKAY);
    // Low-level samples, written while idle
    wr(`APVM_IDX_LEFT_UP, 16'h1234, `APVM_RESP_OKAY);
    wr(`APVM_IDX_LEFT_LO, 16'h5600, `APVM_RESP_OKAY);
    wr(`APVM_IDX_RIGHT_UP, 16'hF000, `APVM_RESP_OKAY);
    wr(`APVM_IDX_RIGHT_LO, 16'h0000, `APVM_RESP_OKAY);
    wr(`APVM_IDX_VOLUME, 16'hC100, `APVM_RESP_OKAY);
    wr(`APVM_IDX_RATE_HI, 16'h0008, `APVM_RESP_OKAY);
    waitFor(0);
    waitFor(0);
    check("playGap", playGap, 256);
    check("left", heldSample.left[19:0], 20'h091A2);
    check("right", heldSample.right[19:0], 20'hF0000);
    check("convClkEn", convClkEn, 1'b1);
    check("extGap", extGap, 4);
    // Mode change only with the rate word at zero
    wr(`APVM_IDX_RATE_HI, 16'h0000, `APVM_RESP_OKAY);
    // A request on the write's last edge must be counted before the snapshot
    @(posedge clock);
    n0 = playTotal;
    repeat (300) @(posedge clock);
    check("convClkEn", convClkEn, 1'b0);
    check("idlePulses", playTotal, n0);
    // Mid-run reset, so the capped run starts from a cleared accumulator
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    check("convClkEn", convClkEn, 1'b0);
    rd(`APVM_IDX_VOLUME, `APVM_RST16, `APVM_RESP_OKAY);
    // Factory bits left at their reset value
    wr(`APVM_IDX_TEST_CTRL, 16'h1800, `APVM_RESP_OKAY);
    rd(`APVM_IDX_TEST_CTRL, 16'h1800, `APVM_RESP_OKAY);
    wr(`APVM_IDX_RATE_LO, 16'hFFFF, `APVM_RESP_OKAY);
    wr(`APVM_IDX_RATE_HI, 16'h000F, `APVM_RESP_OKAY);
    waitFor(0);
    waitFor(0);
    check("playGap", playGap, 128);
    check("extGap", extGap, 8);
    // Full-scale primary, then a secondary pair that overflows on the left
    wr(`APVM_IDX_LEFT_UP, 16'h7FFF, `APVM_RESP_OKAY);
    wr(`APVM_IDX_LEFT_LO, 16'hFF00, `APVM_RESP_OKAY);
    wr(`APVM_IDX_RIGHT_UP, 16'h8000, `APVM_RESP_OKAY);
    wr(`APVM_IDX_RIGHT_LO, 16'h0000, `APVM_RESP_OKAY);
    wr(`APVM_IDX_VOLUME, 16'h0000, `APVM_RESP_OKAY);
    waitFor(0);
    waitFor(0);
    check("left", heldSample.left[19:0], 20'h7FFFF);
    check("right", heldSample.right[19:0], 20'h80000);
    wr(`APVM_IDX_SEC_CFG, 16'h003F, `APVM_RESP_OKAY);
    wr(`APVM_IDX_SEC_L_UP, 16'h7FFF, `APVM_RESP_OKAY);
    rd(`APVM_IDX_SEC_CFG, 16'h003F, `APVM_RESP_OKAY);
    wr(`APVM_IDX_SEC_R_UP, 16'h0010, `APVM_RESP_OKAY);
    rd(`APVM_IDX_SEC_CFG, 16'h203F, `APVM_RESP_OKAY);
    wr(`APVM_IDX_SEC_CFG, 16'h103F, `APVM_RESP_OKAY);
    waitFor(1);
    rd(`APVM_IDX_SEC_CFG, 16'h103F, `APVM_RESP_OKAY);
    check("left", heldSample.left[19:0], 20'h7FFFF);
    check("right", heldSample.right[19:0], 20'h80100);
    wr(`APVM_IDX_SEC_L_UP, 16'h7FFF, `APVM_RESP_OKAY);
    wr(`APVM_IDX_SEC_R_UP, 16'h0010, `APVM_RESP_OKAY);
    waitFor(1);
    check("secGap", secGap, 64);
    repeat (80) @(posedge clock);
    rd(`APVM_IDX_SEC_CFG, 16'h503F, `APVM_RESP_OKAY);
    check("right", heldSample.right[19:0], 20'h80100);
    wr(`APVM_IDX_SEC_CFG, 16'h4000, `APVM_RESP_OKAY);
    rd(`APVM_IDX_SEC_CFG, 16'h0000, `APVM_RESP_OKAY);
    repeat (5) @(posedge clock);
    check("right", heldSample.right[19:0], 20'h80000);
    give_verdict();
  end
endmodule
